// [hdl/stm_consts.svh]
`ifndef STM_CONSTS_SVH
`define STM_CONSTS_SVH

// register offsets as seen in the spi address field
`define STM_ADDR_FUNC       7'h00
`define STM_ADDR_HIGH       7'h1a
`define STM_ADDR_LOW        7'h1b
`define STM_ADDR_MEAS       7'h45
`define STM_ADDR_TEMP       7'h46
`define STM_ADDR_DIAG       7'h5f

// function control bit positions
`define STM_FUNC_MEAS_BIT   6
`define STM_FUNC_OUT2_BIT   2
`define STM_FUNC_OUT1_BIT   1

// diagnostic bit positions
`define STM_DIAG_OUT1_OK    7
`define STM_DIAG_OUT2_OK    6
`define STM_DIAG_GATE_OK    5
`define STM_DIAG_OVERTEMP   4
`define STM_DIAG_LOW        3
`define STM_DIAG_HIGH       2
`define STM_DIAG_BADCMD     1
`define STM_DIAG_GATE_FAULT 0

// reset and fill values
`define STM_HIGH_RST        8'hff
`define STM_LOW_RST         8'h00
`define STM_MEAS_INVALID    8'h00
`define STM_READ_ZERO       8'h00

// spi frame layout
`define STM_FRAME_BITS      5'h10
`define STM_ADDR_BITS       5'h07
`define STM_BITCNT_MAX      5'h1f

// timing
`define STM_CLK_MHZ         50
`define STM_STARTUP_US      100
`define STM_STARTUP_CYC     (`STM_STARTUP_US * `STM_CLK_MHZ)
`define STM_FILTER_US       10
`define STM_FILTER_CYC      (`STM_FILTER_US * `STM_CLK_MHZ)

`endif

// [hdl/stm_monitor.sv]
`timescale 1ns/1ns
`include "stm_consts.svh"
module stm_monitor #(
	parameter int unsigned STARTUP_CYC = `STM_STARTUP_CYC,
	parameter int unsigned FILTER_CYC  = `STM_FILTER_CYC
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// spi pins
	input  wire logic              spiSclk,
	input  wire logic              spiCsN,
	input  wire logic              spiMosi,
	output logic                   spiMiso,
	// analog front end results
	input  wire stm_pkg::stm_sense_s sense,
	// mode inputs
	input  wire logic              autoRecoverOv,
	input  wire logic              offModeEntry,
	// power stage control
	output logic [1:0]             outEnable,
	output logic [1:0]             gateDrvEn,
	output logic                   failSilent
);
	import stm_pkg::*;

	stm_state_s r;
	stm_state_s n;
	logic [1:0] outOk;

	// two independent filters, one per output
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gFilt
			stm_reg_filter #(
				.FILTER_CYC (FILTER_CYC)
			) uFilt (
				.clk       (clk),
				.rst_n     (rst_n),
				.inWindow  (sense.outInWindow[g]),
				.regulated (outOk[g])
			);
		end
	endgenerate

	logic       sclkRise;
	logic       sclkFall;
	logic       csActive;
	logic       csStart;
	logic       frameEnd;
	logic [7:0] cmdByte;
	logic [7:0] readData;
	logic       wrReq;
	logic [6:0] frmAddr;
	logic [7:0] frmData;
	logic       mapped;
	logic       writable;
	logic       cmdOk;
	logic       cmdBad;
	logic       diagWr;
	logic       outOn;
	logic       measValid;
	logic       lowEv;
	logic       highEv;
	logic       otEv;
	logic       gateLate;
	logic       gateFaultEv;
	logic       failEv;
	logic [7:0] diagValue;
	logic [7:0] measValue;

	always_comb begin
		n = r;
		n.sclkSync = {r.sclkSync[0], spiSclk};
		n.csSync   = {r.csSync[0], spiCsN};
		n.mosiSync = {r.mosiSync[0], spiMosi};
		n.sclkPrev = r.sclkSync[1];
		n.csPrev   = r.csSync[1];
		sclkRise   = r.sclkSync[1] & ~r.sclkPrev;
		sclkFall   = ~r.sclkSync[1] & r.sclkPrev;
		csActive   = ~r.csSync[1];
		csStart    = ~r.csSync[1] & r.csPrev;
		frameEnd   = r.csSync[1] & ~r.csPrev;
		cmdByte    = {r.rxShift[6:0], r.mosiSync[1]};
		wrReq      = r.rxShift[15];
		frmAddr    = r.rxShift[14:8];
		frmData    = r.rxShift[7:0];

		outOn     = |r.outEn;
		measValid = outOn | r.measEn;
		measValue = measValid ? sense.supplyCode : `STM_MEAS_INVALID;
		diagValue = '0;
		diagValue[`STM_DIAG_OUT1_OK]    = outOk[0];
		diagValue[`STM_DIAG_OUT2_OK]    = outOk[1];
		diagValue[`STM_DIAG_GATE_OK]    = sense.gateInWindow;
		diagValue[`STM_DIAG_OVERTEMP]   = r.overtempFlag;
		diagValue[`STM_DIAG_LOW]        = r.lowFlag;
		diagValue[`STM_DIAG_HIGH]       = r.highFlag;
		diagValue[`STM_DIAG_BADCMD]     = r.badCmd;
		diagValue[`STM_DIAG_GATE_FAULT] = r.gateFault;

		// read mux on the address byte just received
		readData = `STM_READ_ZERO;
		case (cmdByte[6:0])
			`STM_ADDR_FUNC: begin
				readData[`STM_FUNC_MEAS_BIT] = r.measEn;
				readData[`STM_FUNC_OUT2_BIT] = r.outEn[1];
				readData[`STM_FUNC_OUT1_BIT] = r.outEn[0];
			end
			`STM_ADDR_HIGH: readData = r.highLimit;
			`STM_ADDR_LOW:  readData = r.lowLimit;
			`STM_ADDR_MEAS: readData = measValue;
			`STM_ADDR_TEMP: readData = sense.tempCode;
			`STM_ADDR_DIAG: readData = diagValue;
			default:        readData = `STM_READ_ZERO;
		endcase

		// command check at the end of the frame
		case (frmAddr)
			`STM_ADDR_FUNC, `STM_ADDR_HIGH, `STM_ADDR_LOW,
			`STM_ADDR_DIAG: begin
				mapped   = 1'b1;
				writable = 1'b1;
			end
			`STM_ADDR_MEAS, `STM_ADDR_TEMP: begin
				mapped   = 1'b1;
				writable = 1'b0;
			end
			default: begin
				mapped   = 1'b0;
				writable = 1'b0;
			end
		endcase
		cmdOk  = (r.bitCnt == `STM_FRAME_BITS) & mapped
			& (writable | ~wrReq);
		cmdBad = frameEnd & ~cmdOk;
		diagWr = frameEnd & cmdOk & wrReq & (frmAddr == `STM_ADDR_DIAG);

		// spi shifter, mode 0, msb first
		if (csStart) begin
			n.bitCnt = '0;
		end else if (csActive && sclkRise) begin
			n.rxShift = {r.rxShift[14:0], r.mosiSync[1]};
			if (r.bitCnt != `STM_BITCNT_MAX) begin
				n.bitCnt = r.bitCnt + 5'h01;
			end
			if (r.bitCnt == `STM_ADDR_BITS) begin
				n.txShift = readData;
			end
		end else if (csActive && sclkFall) begin
			n.miso    = r.txShift[7];
			n.txShift = {r.txShift[6:0], 1'b0};
		end

		// register writes; invalid frames write no register, they only set badCmd
		if (frameEnd && cmdOk && wrReq) begin
			case (frmAddr)
				`STM_ADDR_FUNC: begin
					n.measEn   = frmData[`STM_FUNC_MEAS_BIT];
					n.outEn[1] = frmData[`STM_FUNC_OUT2_BIT];
					n.outEn[0] = frmData[`STM_FUNC_OUT1_BIT];
				end
				`STM_ADDR_HIGH: n.highLimit = frmData;
				`STM_ADDR_LOW:  n.lowLimit = frmData;
				default:        n.highLimit = r.highLimit;
			endcase
		end

		// startup window of the gate drive supply
		if (!outOn) begin
			n.startCnt     = '0;
			n.startDone    = 1'b0;
			n.gateEverGood = 1'b0;
		end else begin
			if (r.startCnt != STARTUP_CYC) begin
				n.startCnt = r.startCnt + 32'h1;
			end else begin
				n.startDone = 1'b1;
			end
			n.gateEverGood = r.gateEverGood | sense.gateInWindow;
		end

		lowEv       = measValid & (sense.supplyCode < r.lowLimit);
		highEv      = measValid & (sense.supplyCode > r.highLimit);
		otEv        = sense.overTemp;
		gateLate    = outOn & r.startDone & ~sense.gateInWindow;
		// one shot at the end of startup, so a diag write can clear it
		gateFaultEv = outOn & ~r.startDone & (r.startCnt == STARTUP_CYC)
			& ~r.gateEverGood & ~sense.gateInWindow;
		failEv      = highEv | otEv | gateLate | gateFaultEv;

		// clears first, events after, so a same-cycle event wins
		if (diagWr || offModeEntry) begin
			n.overtempFlag = 1'b0;
			n.lowFlag      = 1'b0;
			n.highFlag     = 1'b0;
			n.badCmd       = 1'b0;
		end
		if (diagWr) begin
			n.gateFault = 1'b0;
		end
		if (otEv) n.overtempFlag = 1'b1;
		if (lowEv) n.lowFlag = 1'b1;
		if (highEv) n.highFlag = 1'b1;
		if (cmdBad) n.badCmd = 1'b1;
		if (gateFaultEv) n.gateFault = 1'b1;

		// fail silent ends only by off mode or overvoltage recovery
		if (offModeEntry) begin
			n.failSilent = 1'b0;
		end else if (r.failSilent && r.ovOnly && autoRecoverOv
			&& !highEv) begin
			n.failSilent = 1'b0;
		end
		if (failEv) begin
			n.failSilent = 1'b1;
			n.ovOnly     = ~(otEv | gateLate | gateFaultEv)
				& (~r.failSilent | r.ovOnly);
		end

		// gate enables; undervoltage blocks without latching
		for (int i = 0; i < 2; i++) begin
			n.gateDrv[i] = r.outEn[i] & r.startDone & sense.gateInWindow
				& ~n.failSilent & ~lowEv;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r           <= '0;
			r.sclkSync  <= 2'h0;
			r.csSync    <= 2'h3;
			r.csPrev    <= 1'b1;
			r.highLimit <= `STM_HIGH_RST;
			r.lowLimit  <= `STM_LOW_RST;
		end else begin
			r <= n;
		end
	end

	assign spiMiso    = r.miso;
	assign outEnable  = r.outEn & {2{~r.failSilent}};
	assign gateDrvEn  = r.gateDrv;
	assign failSilent = r.failSilent;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_gate_needs_good: assert property (
		|gateDrvEn |-> $past(sense.gateInWindow) && !failSilent)
		else $error("gates enabled without good gate supply");

	a_high_fail_silent: assert property (
		highEv |=> failSilent && r.highFlag && gateDrvEn == 2'h0)
		else $error("overvoltage did not stop the gates");

	a_low_stops_gates: assert property (
		lowEv && !diagWr |=> r.lowFlag && gateDrvEn == 2'h0)
		else $error("undervoltage did not stop the gates");

	a_overtemp_silent: assert property (
		otEv |=> failSilent && r.overtempFlag)
		else $error("overtemperature not latched");

	a_gate_fault_set: assert property (
		gateFaultEv |=> r.gateFault && failSilent)
		else $error("late gate supply not flagged");

	a_diag_clears: assert property (
		diagWr && !otEv && !lowEv && !highEv
		|=> !r.overtempFlag && !r.lowFlag && !r.highFlag && !r.badCmd)
		else $error("diagnostic write left flags set");

	a_stay_silent: assert property (
		failSilent && diagWr && !offModeEntry && !autoRecoverOv
		|=> failSilent)
		else $error("flag clear released fail silent");

	a_bad_cmd_flag: assert property (
		cmdBad |=> r.badCmd ##0 $stable(r.highLimit))
		else $error("bad command not flagged");

	a_flag_sticky: assert property (
		r.badCmd && !diagWr && !offModeEntry |=> r.badCmd)
		else $error("bad command flag dropped on its own");

	a_meas_gated: assert property (
		csActive && !csStart && sclkRise && r.bitCnt == `STM_ADDR_BITS
		&& cmdByte[6:0] == `STM_ADDR_MEAS && !(|r.outEn) && !r.measEn
		|=> r.txShift == `STM_MEAS_INVALID)
		else $error("measurement shown while not valid");

	c_diag_write: cover property (diagWr ##1 !r.badCmd);
	c_ov_recover: cover property (failSilent && r.ovOnly ##1 !failSilent);
	c_gate_fault: cover property (gateFaultEv);
	c_gates_run:  cover property (gateDrvEn == 2'h3);
endmodule

// [hdl/stm_pkg.sv]
package stm_pkg;

	typedef struct packed {
		logic [7:0] supplyCode;
		logic [7:0] tempCode;
		logic       overTemp;
		logic       gateInWindow;
		logic [1:0] outInWindow;
	} stm_sense_s;

	typedef struct packed {
		logic [1:0]  sclkSync;
		logic [1:0]  csSync;
		logic [1:0]  mosiSync;
		logic        sclkPrev;
		logic        csPrev;
		logic [4:0]  bitCnt;
		logic [15:0] rxShift;
		logic [7:0]  txShift;
		logic        miso;
		logic        measEn;
		logic [1:0]  outEn;
		logic [7:0]  highLimit;
		logic [7:0]  lowLimit;
		logic        overtempFlag;
		logic        lowFlag;
		logic        highFlag;
		logic        badCmd;
		logic        gateFault;
		logic        failSilent;
		logic        ovOnly;
		logic [31:0] startCnt;
		logic        startDone;
		logic        gateEverGood;
		logic [1:0]  gateDrv;
	} stm_state_s;

	typedef struct packed {
		logic [15:0] cnt;
		logic        regulated;
	} stm_filt_s;

endpackage

// [hdl/stm_reg_filter.sv]
`timescale 1ns/1ns
module stm_reg_filter #(
	parameter int unsigned FILTER_CYC = 500
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// window comparator and filtered flag
	input  wire logic inWindow,
	output logic      regulated
);
	import stm_pkg::*;

	stm_filt_s r;
	stm_filt_s n;

	// a flip only after the level held longer than the filter time
	always_comb begin
		n = r;
		if (inWindow == r.regulated) begin
			n.cnt = 16'h0000;
		end else if (r.cnt == 16'(FILTER_CYC)) begin
			n.cnt       = 16'h0000;
			n.regulated = inWindow;
		end else begin
			n.cnt = r.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign regulated = r.regulated;
endmodule

// [verif/stm_host_model.sv]
`timescale 1ns/1ns
module stm_host_model (
	// clock
	input  wire logic clk,
	// spi pins
	output logic      spiSclk,
	output logic      spiCsN,
	output logic      spiMosi,
	input  wire logic spiMiso
);
	initial begin
		spiSclk = 1'b0;
		spiCsN  = 1'b1;
		spiMosi = 1'b0;
	end

	// mode 0 frame, msb first; sclk high 5 clk, low 6 clk
	task automatic frame(input logic [15:0] word, input int nbits,
		output logic [7:0] rdata);
		int i;
		rdata = 8'h00;
		@(posedge clk);
		spiCsN <= 1'b0;
		for (i = 0; i < nbits; i++) begin
			@(posedge clk);
			spiMosi <= word[15 - i];
			repeat (5) @(posedge clk);
			// miso has settled since the previous fall
			if (i >= 8)
				rdata = {rdata[6:0], spiMiso};
			spiSclk <= 1'b1;
			repeat (5) @(posedge clk);
			spiSclk <= 1'b0;
		end
		repeat (5) @(posedge clk);
		spiCsN  <= 1'b1;
		// released line must not keep the last bit
		spiMosi <= ~spiMosi;
		repeat (8) @(posedge clk);
	endtask
endmodule

// [verif/supply_temp_diag_monitor_test.sv]
`timescale 1ns/1ns
module supply_temp_diag_monitor_test;
	import stm_pkg::*;
	logic       clk;
	logic       rst_n;
	logic       spiSclk;
	logic       spiCsN;
	logic       spiMosi;
	logic       spiMiso;
	stm_sense_s sense;
	logic       autoRecoverOv;
	logic       offModeEntry;
	logic [1:0] outEnable;
	logic [1:0] gateDrvEn;
	logic       failSilent;
	logic [7:0] junk;
	int         err_total;
	int         total_checks;

	stm_monitor #(.STARTUP_CYC(20), .FILTER_CYC(4)) u_stm_monitor (
		.clk          (clk),
		.rst_n        (rst_n),
		.spiSclk      (spiSclk),
		.spiCsN       (spiCsN),
		.spiMosi      (spiMosi),
		.spiMiso      (spiMiso),
		.sense        (sense),
		.autoRecoverOv(autoRecoverOv),
		.offModeEntry (offModeEntry),
		.outEnable    (outEnable),
		.gateDrvEn    (gateDrvEn),
		.failSilent   (failSilent)
	);

	stm_host_model u_stm_host_model (
		.clk    (clk),
		.spiSclk(spiSclk),
		.spiCsN (spiCsN),
		.spiMosi(spiMosi),
		.spiMiso(spiMiso)
	);

	always #10 clk = ~clk;

	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_stm_host_model.frame({1'b1, a, d}, 16, junk);
	endtask

	task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] q;
		u_stm_host_model.frame({1'b0, a, 8'h00}, 16, q);
		chk($sformatf("reg %h", a), q, exp);
	endtask

	task automatic fs(input logic exp);
		chk("failSilent", {7'h00, failSilent}, {7'h00, exp});
	endtask

	task automatic offPulse;
		@(posedge clk);
		offModeEntry <= 1'b1;
		@(posedge clk);
		offModeEntry <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// sense levels change only at clock edges through these
	task automatic supply(input logic [7:0] code);
		@(posedge clk);
		sense.supplyCode <= code;
		repeat (4) @(posedge clk);
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		err_total++;
		summarize();
	end

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		sense = '0;
		sense.supplyCode = 8'h40;
		sense.tempCode = 8'h83;
		autoRecoverOv = 1'b0;
		offModeEntry = 1'b0;
		err_total = 0;
		total_checks = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rdc(7'h1a, 8'hff);
		rdc(7'h1b, 8'h00);
		rdc(7'h45, 8'h00);
		rdc(7'h46, 8'h83);
		wr(7'h00, 8'h40);
		rdc(7'h45, 8'h40);
		wr(7'h1a, 8'h80);
		rdc(7'h1a, 8'h80);
		wr(7'h1b, 8'h20);
		rdc(7'h1b, 8'h20);
		// refused frames: read-only target, a short frame, then an unmapped read
		wr(7'h45, 8'h11);
		rdc(7'h5f, 8'h02);
		wr(7'h5f, 8'h00);
		rdc(7'h5f, 8'h00);
		u_stm_host_model.frame({1'b1, 7'h1a, 8'h55}, 15, junk);
		rdc(7'h1a, 8'h80);
		rdc(7'h5f, 8'h02);
		wr(7'h5f, 8'h00);
		rdc(7'h30, 8'h00);
		rdc(7'h5f, 8'h02);
		wr(7'h5f, 8'h00);
		supply(8'h81);
		fs(1'b1);
		supply(8'h40);
		rdc(7'h5f, 8'h04);
		wr(7'h5f, 8'h00);
		rdc(7'h5f, 8'h00);
		fs(1'b1);
		offPulse();
		fs(1'b0);
		autoRecoverOv <= 1'b1;
		supply(8'h81);
		fs(1'b1);
		supply(8'h40);
		fs(1'b0);
		autoRecoverOv <= 1'b0;
		offPulse();
		supply(8'h10);
		rdc(7'h5f, 8'h08);
		chk("gateDrvEn", {6'h00, gateDrvEn}, 8'h00);
		supply(8'h40);
		offPulse();
		sense.overTemp <= 1'b1;
		repeat (4) @(posedge clk);
		fs(1'b1);
		sense.overTemp <= 1'b0;
		rdc(7'h5f, 8'h10);
		offPulse();
		rdc(7'h5f, 8'h00);
		fs(1'b0);
		// out1 on with the gate supply never in its window
		wr(7'h00, 8'h42);
		rdc(7'h00, 8'h42);
		repeat (40) @(posedge clk);
		rdc(7'h5f, 8'h01);
		fs(1'b1);
		wr(7'h5f, 8'h00);
		rdc(7'h5f, 8'h00);
		fs(1'b1);
		sense.gateInWindow <= 1'b1;
		offPulse();
		fs(1'b0);
		chk("gateDrvEn", {6'h00, gateDrvEn}, 8'h01);
		chk("outEnable", {6'h00, outEnable}, 8'h01);
		sense.outInWindow <= 2'b01;
		repeat (12) @(posedge clk);
		rdc(7'h5f, 8'ha0);
		sense.outInWindow <= 2'b10;
		repeat (12) @(posedge clk);
		rdc(7'h5f, 8'h60);
		supply(8'h10);
		chk("gateDrvEn", {6'h00, gateDrvEn}, 8'h00);
		supply(8'h40);
		chk("gateDrvEn", {6'h00, gateDrvEn}, 8'h01);
		sense.gateInWindow <= 1'b0;
		repeat (4) @(posedge clk);
		fs(1'b1);
		chk("gateDrvEn", {6'h00, gateDrvEn}, 8'h00);
		summarize();
	end
endmodule
